// ===== shared/wake_frame_map.vh
// register map, field positions and reset values of the wake detector
`ifndef WAKE_FRAME_MAP_VH
`define WAKE_FRAME_MAP_VH
`define ADDR_W              8
`define REG_FILTER_MASK     8'h00
`define REG_FILTER_CMD      8'h10
`define REG_FILTER_OFFSET   8'h20
`define REG_FILTER_CRC      8'h30
`define REG_WAKE_CTRL       8'h40
`define REG_STATION_LO      8'h44
`define REG_STATION_HI      8'h48
`define CMD_ENABLE_BIT      0
`define CMD_MCAST_BIT       3
`define CTRL_PKT_EN_BIT     1
`define CTRL_PKT_RX_BIT     5
`define CTRL_FRAME_RX_BIT   6
`define CTRL_PKT_IRQ_BIT    8
`define CTRL_PKT_PME_BIT    9
`define CTRL_FRAME_IRQ_BIT  10
`define CTRL_FRAME_PME_BIT  11
`define CTRL_D1_BIT         16
`define CRC_SEED            16'hFFFF
`define CRC_POLY_REFL       16'hA001
`define SYNC_BYTE           8'hFF
`define SYNC_LEN            3'h6
`define REPEAT_COUNT        5'h10
`define ADDR_FIELD_END      7'h0C
`define MASK_LEN            6'h1F
`define OFFSET_RESET        8'h0C
`endif

// ===== rtl/wake_frame_detector.v
// wake-up frame filters and wake packet detector on the mac receive path
//
// Behaviour
// - four independent filters, each programmable except mask bit 31, which stays zero
// - mask bit j feeds byte offset+j
// - command bit 3 picks multicast or unicast
// - disabled filter never reports a match
// - offset field indexes first examined byte
// - computed crc equal to match value wakes
// - packet enable suppresses normal reception
// - detection notifies via irq or pme
// - detection sets packet received status bit
// - clearing enable resumes normal reception
// - own unicast or broadcast frames examined
// - multicast frames also accepted as packets
// - search six 0xFF bytes after addresses
// - sixteen back-to-back station addresses required
// - broken run restarts sync search
// - pattern may sit anywhere after the address fields
// - in d0 packet detection needs enable bit; frame detection stays off
// - entering d1 enables both detectors
`timescale 1ns/1ps
`include "wake_frame_map.vh"

module wake_frame_detector #(
  parameter FILTERS = 4
) (
  input  wire        clock,
  input  wire        rst_n,
  input  wire [7:0]  address,
  input  wire [31:0] write_data,
  input  wire        write_strobe,
  input  wire        read_strobe,
  output reg  [31:0] read_data,
  input  wire        rx_valid,
  input  wire [7:0]  rx_data,
  input  wire        rx_start,
  input  wire        rx_end,
  output reg         rx_pass_enable,
  output reg         host_irq,
  output reg         power_event_out
);

  // ==========================================================
  // reset release
  reg        rst_meta;
  reg        rst_sync_n;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // ==========================================================
  // registers
  reg [31:0] wake_filter_byte_mask [0:FILTERS-1];
  reg [3:0]  wake_filter_command   [0:FILTERS-1];
  reg [7:0]  wake_filter_offset    [0:FILTERS-1];
  reg [15:0] wake_filter_crc_match [0:FILTERS-1];
  reg        wake_pkt_enable;
  reg        wake_pkt_received;
  reg        wake_frame_received;
  reg        pkt_irq_en;
  reg        pkt_pme_en;
  reg        frame_irq_en;
  reg        frame_pme_en;
  reg        d1_state;
  reg [47:0] station_addr;
  reg        pkt_hit;
  reg        frame_hit;
  integer    i;
  integer    j;
  integer    k;

  wire       wr_ctrl = write_strobe && (address == `REG_WAKE_CTRL);
  // status bits clear on a written one, but a fresh hit wins
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      for (i = 0; i < FILTERS; i = i + 1) begin
        wake_filter_byte_mask[i] <= 32'h0000_0000;
        wake_filter_command[i]   <= 4'h0;
        wake_filter_offset[i]    <= `OFFSET_RESET;
        wake_filter_crc_match[i] <= 16'h0000;
      end
      wake_pkt_enable     <= 1'b0;
      wake_pkt_received   <= 1'b0;
      wake_frame_received <= 1'b0;
      pkt_irq_en          <= 1'b0;
      pkt_pme_en          <= 1'b0;
      frame_irq_en        <= 1'b0;
      frame_pme_en        <= 1'b0;
      d1_state            <= 1'b0;
      station_addr        <= 48'h0000_0000_0000;
    end else begin
      if (write_strobe) begin
        for (i = 0; i < FILTERS; i = i + 1) begin
          if (address == `REG_FILTER_MASK + 4 * i)
            wake_filter_byte_mask[i] <= {1'b0, write_data[30:0]};
          else if (address == `REG_FILTER_CMD + 4 * i)
            wake_filter_command[i] <= write_data[3:0];
          else if (address == `REG_FILTER_OFFSET + 4 * i)
            wake_filter_offset[i] <= write_data[7:0];
          else if (address == `REG_FILTER_CRC + 4 * i)
            wake_filter_crc_match[i] <= write_data[15:0];
        end
        if (address == `REG_STATION_LO)
          station_addr[31:0] <= write_data;
        else if (address == `REG_STATION_HI)
          station_addr[47:32] <= write_data[15:0];
      end
      if (wr_ctrl) begin
        wake_pkt_enable <= write_data[`CTRL_PKT_EN_BIT];
        pkt_irq_en      <= write_data[`CTRL_PKT_IRQ_BIT];
        pkt_pme_en      <= write_data[`CTRL_PKT_PME_BIT];
        frame_irq_en    <= write_data[`CTRL_FRAME_IRQ_BIT];
        frame_pme_en    <= write_data[`CTRL_FRAME_PME_BIT];
        d1_state        <= write_data[`CTRL_D1_BIT];
      end
      if (pkt_hit)
        wake_pkt_received <= 1'b1;
      else if (wr_ctrl && write_data[`CTRL_PKT_RX_BIT])
        wake_pkt_received <= 1'b0;
      if (frame_hit)
        wake_frame_received <= 1'b1;
      else if (wr_ctrl && write_data[`CTRL_FRAME_RX_BIT])
        wake_frame_received <= 1'b0;
    end
  end

  // ==========================================================
  // register read, one cycle later
  reg [31:0] next_read_data;
  always @* begin
    next_read_data = 32'h0000_0000;
    for (j = 0; j < FILTERS; j = j + 1) begin
      if (address == `REG_FILTER_MASK + 4 * j)
        next_read_data = wake_filter_byte_mask[j];
      else if (address == `REG_FILTER_CMD + 4 * j)
        next_read_data = {28'h0000000, wake_filter_command[j][3], 2'b00, wake_filter_command[j][0]};
      else if (address == `REG_FILTER_OFFSET + 4 * j)
        next_read_data = {24'h000000, wake_filter_offset[j]};
      else if (address == `REG_FILTER_CRC + 4 * j)
        next_read_data = {16'h0000, wake_filter_crc_match[j]};
    end
    if (address == `REG_WAKE_CTRL) begin
      next_read_data[`CTRL_PKT_EN_BIT]    = wake_pkt_enable;
      next_read_data[`CTRL_PKT_RX_BIT]    = wake_pkt_received;
      next_read_data[`CTRL_FRAME_RX_BIT]  = wake_frame_received;
      next_read_data[`CTRL_PKT_IRQ_BIT]   = pkt_irq_en;
      next_read_data[`CTRL_PKT_PME_BIT]   = pkt_pme_en;
      next_read_data[`CTRL_FRAME_IRQ_BIT] = frame_irq_en;
      next_read_data[`CTRL_FRAME_PME_BIT] = frame_pme_en;
      next_read_data[`CTRL_D1_BIT]        = d1_state;
    end else if (address == `REG_STATION_LO)
      next_read_data = station_addr[31:0];
    else if (address == `REG_STATION_HI)
      next_read_data = {16'h0000, station_addr[47:32]};
  end

  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n)
      read_data <= 32'h0000_0000;
    else if (read_strobe)
      read_data <= next_read_data;
    else
      read_data <= 32'h0000_0000;
  end

  // ==========================================================
  // enables per power state
  wire pkt_active   = wake_pkt_enable || d1_state;
  wire frame_active = d1_state;

  // ==========================================================
  // frame position and destination class
  reg [10:0] byte_idx;
  reg        dest_mcast;
  reg        dest_bcast;
  reg        dest_own;
  reg        in_frame;
  wire [7:0] sta_byte = station_addr[8 * byte_idx[2:0] +: 8];
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      byte_idx   <= 11'h000;
      dest_mcast <= 1'b0;
      dest_bcast <= 1'b0;
      dest_own   <= 1'b0;
      in_frame   <= 1'b0;
    end else if (rx_start) begin
      byte_idx   <= 11'h000;
      dest_bcast <= 1'b1;
      dest_own   <= 1'b1;
      in_frame   <= 1'b1;
    end else if (rx_end) begin
      // bytes after the end pulse belong to no frame
      in_frame   <= 1'b0;
    end else if (rx_valid && in_frame) begin
      if (byte_idx != 11'h7FF)
        byte_idx <= byte_idx + 11'h001;
      if (byte_idx == 11'h000)
        dest_mcast <= rx_data[0];
      if (byte_idx < 11'h006) begin
        if (rx_data != 8'hFF)
          dest_bcast <= 1'b0;
        if (rx_data != sta_byte)
          dest_own <= 1'b0;
      end
    end
  end

  // ==========================================================
  // wake-up frame filters
  // one crc engine per filter, all fed the same byte
  wire [15:0] crc [0:FILTERS-1];
  genvar      g;
  generate
    for (g = 0; g < FILTERS; g = g + 1) begin : filter_gen
      masked_crc16 crc_u (
        .clock     (clock),
        .rst_n     (rst_sync_n),
        .restart   (rx_start),
        .take      (rx_valid && in_frame),
        .data      (rx_data),
        .byte_idx  (byte_idx),
        .byte_mask (wake_filter_byte_mask[g]),
        .offset    (wake_filter_offset[g]),
        .crc       (crc[g])
      );
    end
  endgenerate

  reg        next_frame_hit;
  always @* begin
    next_frame_hit = 1'b0;
    for (k = 0; k < FILTERS; k = k + 1)
      if (wake_filter_command[k][`CMD_ENABLE_BIT]
          && (wake_filter_command[k][`CMD_MCAST_BIT] == dest_mcast)
          && crc[k] == wake_filter_crc_match[k])
        next_frame_hit = 1'b1;
  end

  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n)
      frame_hit <= 1'b0;
    else if (rx_end && in_frame && frame_active)
      frame_hit <= next_frame_hit;
    else
      frame_hit <= 1'b0;
  end

  // ==========================================================
  // wake packet search; a failing byte is rechecked as a possible sync start
  localparam SEARCH_SYNC = 1'b0;
  localparam MATCH_ADDR  = 1'b1;
  reg        state;
  reg [2:0]  sync_cnt;
  reg [2:0]  addr_pos;
  reg [4:0]  rep_cnt;
  reg        pkt_found;
  wire [7:0] want = station_addr[8 * addr_pos +: 8];
  wire       eligible = dest_own || dest_bcast || dest_mcast;
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state     <= SEARCH_SYNC;
      sync_cnt  <= 3'h0;
      addr_pos  <= 3'h0;
      rep_cnt   <= 5'h00;
      pkt_found <= 1'b0;
      pkt_hit   <= 1'b0;
    end else begin
      pkt_hit <= 1'b0;
      if (rx_start) begin
        state     <= SEARCH_SYNC;
        sync_cnt  <= 3'h0;
        pkt_found <= 1'b0;
      end else if (rx_valid && in_frame && byte_idx >= {4'h0, `ADDR_FIELD_END}) begin
        case (state)
          SEARCH_SYNC: begin
            if (rx_data == `SYNC_BYTE) begin
              if (sync_cnt == `SYNC_LEN - 3'h1) begin
                state    <= MATCH_ADDR;
                addr_pos <= 3'h0;
                rep_cnt  <= 5'h00;
              end else
                sync_cnt <= sync_cnt + 3'h1;
            end else
              sync_cnt <= 3'h0;
          end
          MATCH_ADDR: begin
            if (rx_data == want) begin
              if (addr_pos == 3'h5) begin
                addr_pos <= 3'h0;
                if (rep_cnt == `REPEAT_COUNT - 5'h01) begin
                  pkt_found <= 1'b1;
                  state     <= SEARCH_SYNC;
                  sync_cnt  <= 3'h0;
                end else
                  rep_cnt <= rep_cnt + 5'h01;
              end else
                addr_pos <= addr_pos + 3'h1;
            end else if (rx_data == `SYNC_BYTE && addr_pos == 3'h0 && rep_cnt == 5'h00) begin
              // a sync run longer than six bytes stays armed
              addr_pos <= 3'h0;
            end else begin
              state    <= SEARCH_SYNC;
              sync_cnt <= (rx_data == `SYNC_BYTE) ? 3'h1 : 3'h0;
            end
          end
          default: state <= SEARCH_SYNC;
        endcase
      end
      if (rx_end && in_frame && pkt_active && eligible && pkt_found)
        pkt_hit <= 1'b1;
    end
  end

  // ==========================================================
  // outputs
  always @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rx_pass_enable  <= 1'b1;
      host_irq        <= 1'b0;
      power_event_out <= 1'b0;
    end else begin
      rx_pass_enable  <= !wake_pkt_enable;
      host_irq        <= (wake_pkt_received && pkt_irq_en) || (wake_frame_received && frame_irq_en);
      power_event_out <= (wake_pkt_received && pkt_pme_en) || (wake_frame_received && frame_pme_en);
    end
  end

endmodule // wake_frame_detector

// ==========================================================
// one filter engine: crc-16 over the masked bytes of a frame
module masked_crc16 (
  input  wire        clock,
  input  wire        rst_n,
  input  wire        restart,
  input  wire        take,
  input  wire [7:0]  data,
  input  wire [10:0] byte_idx,
  input  wire [31:0] byte_mask,
  input  wire [7:0]  offset,
  output reg  [15:0] crc
);

  reg [15:0] next_crc;
  reg [10:0] rel;
  integer    b;
  // mask bit 31 is never consulted, so the window is 31 bytes
  always @* begin
    next_crc = crc;
    rel      = byte_idx - {3'b000, offset};
    if (byte_idx >= {3'b000, offset} && rel < {5'h00, `MASK_LEN}
        && byte_mask[rel[4:0]]) begin
      next_crc = crc ^ {8'h00, data};
      for (b = 0; b < 8; b = b + 1)
        next_crc = next_crc[0] ? ((next_crc >> 1) ^ `CRC_POLY_REFL) : (next_crc >> 1);
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      crc <= `CRC_SEED;
    else if (restart)
      crc <= `CRC_SEED;
    else if (take)
      crc <= next_crc;
  end

endmodule // masked_crc16

// ===== testbench/wake_frame_detector_assertions.sv
// port checker of the wake detector
`timescale 1ns/1ps
`include "wake_frame_map.vh"
module wake_frame_checker (
  input wire        clock,
  input wire        rst_n,
  input wire [7:0]  address,
  input wire [31:0] write_data,
  input wire        write_strobe,
  input wire        read_strobe,
  input wire [31:0] read_data,
  input wire        rx_end,
  input wire        rx_pass_enable,
  input wire        host_irq,
  input wire        power_event_out
);
  // ====== properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire ctrl_wr = write_strobe && address == `REG_WAKE_CTRL;
  a_read_idle: assert property (!read_strobe |=> read_data == 32'h0)
    else $error("read data outside slot");
  a_pass_off: assert property (ctrl_wr && write_data[1] |-> ##[1:3] !rx_pass_enable)
    else $error("reception not suppressed");
  a_pass_on: assert property (ctrl_wr && !write_data[1] && !write_data[16] |-> ##[1:3] rx_pass_enable)
    else $error("reception not resumed");
  a_pass_cause: assert property (!$stable(rx_pass_enable) |-> $past(ctrl_wr) || $past(ctrl_wr, 2))
    else $error("pass enable moved alone");
  a_irq_cause: assert property ($rose(host_irq) |-> $past(rx_end, 3))
    else $error("irq without frame end");
  a_pme_cause: assert property ($rose(power_event_out) |-> $past(rx_end, 3))
    else $error("pme without frame end");
  a_notify_off: assert property (ctrl_wr && write_data[11:8] == 4'h0 |-> ##[1:3] !host_irq && !power_event_out)
    else $error("notify not masked");
  a_irq_sticky: assert property ($fell(host_irq) |-> $past(ctrl_wr, 2) || $past(ctrl_wr, 3))
    else $error("irq dropped alone");
  c_irq: cover property ($rose(host_irq));
  c_pme: cover property ($rose(power_event_out));
  c_pass_off: cover property ($fell(rx_pass_enable));
endmodule // wake_frame_checker
bind wake_frame_detector wake_frame_checker chk_u (.clock(clock), .rst_n(rst_n), .address(address),
  .write_data(write_data), .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
  .rx_end(rx_end), .rx_pass_enable(rx_pass_enable), .host_irq(host_irq), .power_event_out(power_event_out));

// ===== testbench/rx_source.sv
// mac receive path model feeding frame bytes
`timescale 1ns/1ps
module rx_source (
  input  wire       clock,
  output reg        rx_valid,
  output reg  [7:0] rx_data,
  output reg        rx_start,
  output reg        rx_end
);
  // ====== frame delivery
  logic [7:0] q[$];
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_start = 1'b0;
    rx_end = 1'b0;
  end
  // idle cycles show a toggling byte so stale data never looks valid
  task automatic send(input logic [31:0] stall);
    int i;
    @(posedge clock);
    rx_start <= 1'b1;
    for (i = 0; i < q.size(); i++) begin
      @(posedge clock);
      rx_start <= 1'b0;
      if (stall[i % 32]) begin
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
        @(posedge clock);
      end
      rx_valid <= 1'b1;
      rx_data <= q[i];
    end
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_data <= ~rx_data;
    rx_end <= 1'b1;
    @(posedge clock);
    rx_end <= 1'b0;
  endtask
endmodule // rx_source

// ===== testbench/tb_top.sv
// self-checking bench of the wake detector
`timescale 1ns/1ps
`include "wake_frame_map.vh"
module tb_top;
  // ====== signals and tasks
  reg         clock, rst_n, write_strobe, read_strobe;
  reg  [7:0]  address, f;
  reg  [31:0] write_data;
  wire [31:0] read_data;
  wire [7:0]  rx_data;
  wire        rx_valid, rx_start, rx_end, rx_pass_enable, host_irq, power_event_out;
  int         fail_count, n_checks, cyc, i, off;
  logic [31:0] seed, d, ctrl, m;
  logic [15:0] c;
  logic [3:0]  cmd;
  logic [7:0]  st[6];
  logic [7:0]  fr[$];
  logic        e;
  int pk[7][4] = '{'{1,0,0,16}, '{0,7,1,16}, '{2,3,0,16}, '{3,2,0,16}, '{0,1,0,15}, '{0,4,2,16}, '{0,2,0,16}};
  wake_frame_detector dut_u (.clock(clock), .rst_n(rst_n), .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_start(rx_start), .rx_end(rx_end), .rx_pass_enable(rx_pass_enable),
    .host_irq(host_irq), .power_event_out(power_event_out));
  rx_source src_u (.clock(clock), .rx_valid(rx_valid), .rx_data(rx_data), .rx_start(rx_start), .rx_end(rx_end));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    write_strobe <= 1'b1;
    address <= a;
    write_data <= v;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    read_strobe <= 1'b1;
    address <= a;
    @(posedge clock);
    read_strobe <= 1'b0;
    @(negedge clock);
    d = read_data;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ====== reference model
  function automatic logic [15:0] crc_of(input logic [31:0] mk, input int o);
    logic [15:0] r;
    int j, b;
    r = 16'hFFFF;
    for (j = 0; j < 31; j++)
      if (mk[j] && o + j < fr.size())
        for (b = 0; b < 8; b++)
          r = (r >> 1) ^ ((r[0] ^ fr[o + j][b]) ? 16'hA001 : 16'h0000);
    return r;
  endfunction
  function automatic logic pkt_hit();
    int p, k;
    logic ok;
    ok = 1'b1;
    for (k = 0; k < 6; k++)
      if (fr[k] !== st[k])
        ok = 1'b0;
    if (!ok && !fr[0][0])
      return 1'b0;
    for (p = 12; p + 102 <= fr.size(); p++) begin
      ok = 1'b1;
      for (k = 0; k < 102; k++)
        if (fr[p + k] !== (k < 6 ? 8'hFF : st[(k - 6) % 6]))
          ok = 1'b0;
      if (ok)
        return 1'b1;
    end
    return 1'b0;
  endfunction
  task automatic reps(input int n);
    int k;
    for (k = 0; k < 6 + 6 * n; k++)
      fr.push_back(k < 6 ? 8'hFF : st[k % 6]);
  endtask
  task automatic build(input int dk, input int pad, input int brk, input int nrep);
    int k;
    fr.delete();
    for (k = 0; k < 6; k++)
      fr.push_back(dk == 0 ? st[k] : dk == 1 ? 8'hFF : dk == 2 ? 8'(2 * k + 1) : st[k] ^ 8'h02);
    for (k = 0; k < 6 + pad; k++)
      fr.push_back(8'(rnd() & 32'h7F));
    if (brk) begin
      reps(5);
      fr.push_back(brk == 2 ? 8'hFF : 8'h5A);
    end
    reps(nrep);
    for (k = 0; k < 4; k++)
      fr.push_back(8'(rnd() & 32'h7F));
  endtask
  // ====== stimulus
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    seed = 32'hA89E7EA1;
    rst_n = 1'b0;
    write_strobe = 1'b0;
    read_strobe = 1'b0;
    address = 8'h00;
    write_data = 32'h0;
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    rd(`REG_FILTER_OFFSET);
    chk(d, 32'h0000000C);
    for (i = 0; i < 4; i++) begin
      wr(8'(4 * i), 32'h80000001 << i);
      wr(8'(`REG_FILTER_CMD + 4 * i), 32'h0);
    end
    for (i = 0; i < 4; i++) begin
      rd(8'(4 * i));
      chk(d, (32'h80000001 << i) & 32'h7FFFFFFF);
    end
    for (i = 0; i < 6; i++)
      st[i] = 8'(rnd()) & 8'hFE;
    wr(`REG_STATION_LO, {st[3], st[2], st[1], st[0]});
    wr(`REG_STATION_HI, {16'h0, st[5], st[4]});
    // entry five runs in d1 without the enable bit, entry six in d0 with neither
    for (i = 0; i < 7; i++) begin
      ctrl = ((i == 5) ? 32'h00010000 : (i == 6) ? 32'h00000000 : 32'h00000002) | ((i % 2) ? 32'h200 : 32'h100);
      wr(`REG_WAKE_CTRL, ctrl);
      repeat (2) @(negedge clock);
      chk(rx_pass_enable, {31'h0, !ctrl[1]});
      build(pk[i][0], pk[i][1], pk[i][2], pk[i][3]);
      e = pkt_hit() && (ctrl[1] || ctrl[16]);
      src_u.q = fr;
      src_u.send(rnd());
      repeat (4) @(negedge clock);
      rd(`REG_WAKE_CTRL);
      chk({d[5], (i % 2) ? power_event_out : host_irq}, {e, e});
      wr(`REG_WAKE_CTRL, ctrl | 32'h20);
    end
    wr(`REG_WAKE_CTRL, 32'h00010C00);
    for (i = 0; i < 5; i++) begin
      f = 8'(4 * (i % 4));
      build((i % 2) ? 2 : 0, 30, 0, 0);
      m = rnd() & 32'h7FFFFFFF;
      off = 12 + rnd() % 8;
      cmd = {1'((i % 2) ^ (i == 4)), 2'b00, 1'(i != 3)};
      c = crc_of(m, off) ^ 16'(i == 2);
      wr(`REG_FILTER_MASK + f, m);
      wr(`REG_FILTER_OFFSET + f, off);
      wr(`REG_FILTER_CRC + f, {16'h0, c});
      wr(`REG_FILTER_CMD + f, {28'h0, cmd});
      e = cmd[0] && cmd[3] == fr[0][0] && crc_of(m, off) == c;
      src_u.q = fr;
      src_u.send(rnd());
      repeat (4) @(negedge clock);
      rd(`REG_WAKE_CTRL);
      chk({d[6], host_irq, power_event_out}, {3{e}});
      wr(`REG_WAKE_CTRL, 32'h00010C40);
      wr(`REG_FILTER_CMD + f, 32'h0);
    end
    wr(`REG_WAKE_CTRL, 32'h0);
    repeat (3) @(negedge clock);
    chk(rx_pass_enable, 1'b1);
    final_report();
  end
endmodule // tb_top
